// ===== hdl/epaper_cmd_defs.vh
`ifndef EPAPER_CMD_DEFS_VH
`define EPAPER_CMD_DEFS_VH

// Timing.
`define SYS_CLK_PERIOD_NS   4
`define OTP_PROG_TIME_NS    8000
`define OTP_PROG_CYCLES     ((`OTP_PROG_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define PROG_CNT_W          12

// Serial link.
`define BYTE_LAST_BIT       3'h7
`define TX_BITS             6'h20

// Command opcodes.
`define CMD_GATE_SETUP      8'h01
`define CMD_GATE_LEVEL      8'h03
`define CMD_SOURCE_LEVEL    8'h04
`define CMD_INIT_PROGRAM    8'h08
`define CMD_INIT_WRITE      8'h09
`define CMD_INIT_READ       8'h0A
`define CMD_DEEP_SLEEP      8'h10
`define CMD_ENTRY_MODE      8'h11
`define CMD_RAM_WRITE       8'h24

// Parameter byte positions.
`define PIDX_A              3'h0
`define PIDX_B              3'h1
`define PIDX_C              3'h2
`define PIDX_D              3'h3
`define PIDX_MAX            3'h7

// Power-up values.
`define RST_GATE_LINES      9'h127
`define RST_GATE_SCAN       3'h0
`define RST_GATE_LEVEL      5'h17
`define RST_SRC_HI1         8'h41
`define RST_SRC_HI2         8'hAC
`define RST_SRC_LO          8'h32
`define RST_INIT_CODE       32'h00000000
`define RST_SLEEP_MODE      2'h0
`define RST_ENTRY_MODE      3'h3

// Entry mode fields.
`define EM_X_INC            0
`define EM_Y_INC            1
`define EM_AXIS             2

// Register word indices (byte address = index * 4).
`define REG_CTRL            6'h00
`define REG_STATUS          6'h01
`define REG_GATE            6'h02
`define REG_GATE_LEVEL      6'h03
`define REG_SOURCE          6'h04
`define REG_INIT_CODE       6'h05
`define REG_ADDR            6'h06

// Control register bits.
`define CTRL_CLK_GATE_ON    0
`define CTRL_SOFT_RESET     1

// AXI responses.
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ===== hdl/epaper_command_decoder.v
// Function
// - Selector low means opcode, high means parameter
// - Opcode 03 sets gate level, default 17h
// - Opcode 04 sets three source levels
// - Opcode 08 programs only while the internal clock is on, busy high meanwhile
// - Initial-code write stores four reserved bytes
// - Opcode 0A reads back initial code
// - Deep sleep survives software reset
// - Sleep parameter 00 normal, 01/11 sleep
// - Busy stays high throughout deep sleep
// - Only hardware reset leaves deep sleep
// - Opcode 11 sets entry mode, default 011
// - Bits one/zero pick Y/X step direction
// - Bit two picks advance axis X/Y
// - Counter advances after each RAM byte
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "epaper_cmd_defs.vh"

module epaper_command_decoder
#(
  parameter XW = 8,
  parameter YW = 9
)
(
  input  wire          sys_clk_i,
  input  wire          rst_i,
  input  wire          scl_i,
  input  wire          sda_i,
  output wire          sda_o,
  output wire          sda_oe_o,
  input  wire          cs_n_i,
  input  wire          dc_i,
  input  wire          pin_driven_restart_n_i,
  output wire          busy_o,
  output wire          ram_we_o,
  output wire [7:0]    ram_data_o,
  output wire [XW-1:0] ram_x_o,
  output wire [YW-1:0] ram_y_o,
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output wire [1:0]    s_axi_bresp,
  output wire          s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output wire [31:0]   s_axi_rdata,
  output wire [1:0]    s_axi_rresp,
  output wire          s_axi_rvalid,
  input  wire          s_axi_rready
);

  // The cycle count is worked out as an integer; only its low bits are meant to reach the counter.
  localparam integer           PROG_CYCLES   = `OTP_PROG_CYCLES;
  localparam [`PROG_CNT_W-1:0] PROG_CNT_INIT = PROG_CYCLES[`PROG_CNT_W-1:0];

  wire            byte_valid;
  wire [7:0]      rx_byte;
  wire            rx_dc;
  wire            scl_fall;
  wire            cs_active;
  wire            dc_level;
  reg             restart_s1_q;
  reg             restart_s2_q;
  wire            hw_rst;
  wire            param_rst;
  wire            sleeping;
  wire            cmd_byte;
  wire            par_byte;

  reg  [8:0]      gate_lines_q;
  reg  [2:0]      gate_scan_q;
  reg  [4:0]      gate_level_q;
  reg  [7:0]      src_hi1_q;
  reg  [7:0]      src_hi2_q;
  reg  [7:0]      src_lo_q;
  reg  [31:0]     init_code_q;
  reg  [1:0]      sleep_mode_q;
  reg  [2:0]      entry_mode_q;
  reg  [7:0]      cmd_q;
  reg  [2:0]      pidx_q;
  reg  [`PROG_CNT_W-1:0] prog_cnt_q;
  reg             busy_q;
  reg  [XW-1:0]   ram_x_q;
  reg  [YW-1:0]   ram_y_q;
  reg             ram_we_q;
  reg  [7:0]      ram_data_q;
  reg  [31:0]     tx_q;
  reg  [5:0]      tx_cnt_q;
  reg             tx_active_q;
  reg             sda_q;
  reg             sda_oe_q;
  reg             clk_gate_on_q;
  reg             soft_rst_q;

  reg             awready_q;
  reg             wready_q;
  reg             aw_full_q;
  reg             w_full_q;
  reg  [5:0]      aw_idx_q;
  reg  [31:0]     wdata_q;
  reg  [3:0]      wstrb_q;
  reg             bvalid_q;
  reg  [1:0]      bresp_q;
  reg             arready_q;
  reg             rvalid_q;
  reg  [31:0]     rdata_q;
  reg  [1:0]      rresp_q;
  reg  [31:0]     rd_data;
  reg             rd_ok;

  serial_byte_receiver u_rx
  (
    .sys_clk_i    (sys_clk_i),
    .rst_i        (hw_rst),
    .scl_i        (scl_i),
    .sda_i        (sda_i),
    .cs_n_i       (cs_n_i),
    .dc_i         (dc_i),
    .byte_valid_o (byte_valid),
    .byte_o       (rx_byte),
    .byte_dc_o    (rx_dc),
    .scl_fall_o   (scl_fall),
    .cs_active_o  (cs_active),
    .dc_level_o   (dc_level)
  );

  // The restart pin is asynchronous to the system clock, so it is synchronised before use.
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      restart_s1_q <= 1'b1;
      restart_s2_q <= 1'b1;
    end
    else
    begin
      restart_s1_q <= pin_driven_restart_n_i;
      restart_s2_q <= restart_s1_q;
    end
  end

  assign hw_rst    = rst_i | ~restart_s2_q;
  assign param_rst = hw_rst | soft_rst_q;
  assign sleeping  = sleep_mode_q[0];
  // Nothing from the link is decoded while asleep, so no command can wake the device.
  assign cmd_byte  = byte_valid & ~rx_dc & ~sleeping;
  assign par_byte  = byte_valid & rx_dc & ~sleeping;

  // Current opcode and position within its parameter list.
  always @(posedge sys_clk_i)
  begin
    if (param_rst)
    begin
      cmd_q  <= 8'h00;
      pidx_q <= `PIDX_A;
    end
    else if (cmd_byte)
    begin
      cmd_q  <= rx_byte;
      pidx_q <= `PIDX_A;
    end
    else if (par_byte && pidx_q != `PIDX_MAX)
      pidx_q <= pidx_q + 3'h1;
  end

  // Command settings; the soft reset restores all of them.
  always @(posedge sys_clk_i)
  begin
    if (param_rst)
    begin
      gate_lines_q <= `RST_GATE_LINES;
      gate_scan_q  <= `RST_GATE_SCAN;
      gate_level_q <= `RST_GATE_LEVEL;
      src_hi1_q    <= `RST_SRC_HI1;
      src_hi2_q    <= `RST_SRC_HI2;
      src_lo_q     <= `RST_SRC_LO;
      init_code_q  <= `RST_INIT_CODE;
      entry_mode_q <= `RST_ENTRY_MODE;
    end
    else if (par_byte)
    begin
      case (cmd_q)
        `CMD_GATE_SETUP:
        begin
          if (pidx_q == `PIDX_A)
            gate_lines_q[7:0] <= rx_byte;
          else if (pidx_q == `PIDX_B)
            gate_lines_q[8] <= rx_byte[0];
          else if (pidx_q == `PIDX_C)
            gate_scan_q <= rx_byte[2:0];
        end
        `CMD_GATE_LEVEL:
        begin
          if (pidx_q == `PIDX_A)
            gate_level_q <= rx_byte[4:0];
        end
        `CMD_SOURCE_LEVEL:
        begin
          if (pidx_q == `PIDX_A)
            src_hi1_q <= rx_byte;
          else if (pidx_q == `PIDX_B)
            src_hi2_q <= rx_byte;
          else if (pidx_q == `PIDX_C)
            src_lo_q <= rx_byte;
        end
        `CMD_INIT_WRITE:
        begin
          // The four bytes are kept verbatim and steer nothing.
          if (pidx_q == `PIDX_A)
            init_code_q[31:24] <= rx_byte;
          else if (pidx_q == `PIDX_B)
            init_code_q[23:16] <= rx_byte;
          else if (pidx_q == `PIDX_C)
            init_code_q[15:8] <= rx_byte;
          else if (pidx_q == `PIDX_D)
            init_code_q[7:0] <= rx_byte;
        end
        `CMD_ENTRY_MODE:
        begin
          if (pidx_q == `PIDX_A)
            entry_mode_q <= rx_byte[2:0];
        end
        default:
        begin
          entry_mode_q <= entry_mode_q;
        end
      endcase
    end
  end

  // Deep sleep ignores the soft reset and clears only on a hardware reset.
  always @(posedge sys_clk_i)
  begin
    if (hw_rst)
      sleep_mode_q <= `RST_SLEEP_MODE;
    else if (par_byte && cmd_q == `CMD_DEEP_SLEEP && pidx_q == `PIDX_A)
      sleep_mode_q <= rx_byte[1:0];
  end

  // Programming runs for a fixed time; it is refused unless the internal clock is on.
  always @(posedge sys_clk_i)
  begin
    if (hw_rst)
    begin
      prog_cnt_q <= {`PROG_CNT_W{1'b0}};
      busy_q     <= 1'b0;
    end
    else
    begin
      if (cmd_byte && rx_byte == `CMD_INIT_PROGRAM && clk_gate_on_q && prog_cnt_q == {`PROG_CNT_W{1'b0}})
        prog_cnt_q <= PROG_CNT_INIT;
      else if (prog_cnt_q != {`PROG_CNT_W{1'b0}})
        prog_cnt_q <= prog_cnt_q - {{(`PROG_CNT_W-1){1'b0}}, 1'b1};
      busy_q <= sleeping | (prog_cnt_q > {{(`PROG_CNT_W-1){1'b0}}, 1'b1}) |
                (cmd_byte && rx_byte == `CMD_INIT_PROGRAM && clk_gate_on_q);
    end
  end

  // Image RAM write port and its address counter.
  always @(posedge sys_clk_i)
  begin
    if (param_rst)
    begin
      ram_x_q    <= {XW{1'b0}};
      ram_y_q    <= {YW{1'b0}};
      ram_we_q   <= 1'b0;
      ram_data_q <= 8'h00;
    end
    else
    begin
      ram_we_q <= 1'b0;
      if (par_byte && cmd_q == `CMD_RAM_WRITE)
      begin
        ram_we_q   <= 1'b1;
        ram_data_q <= rx_byte;
      end
      if (ram_we_q)
      begin
        if (!entry_mode_q[`EM_AXIS])
        begin
          if (entry_mode_q[`EM_X_INC])
            ram_x_q <= ram_x_q + {{(XW-1){1'b0}}, 1'b1};
          else
            ram_x_q <= ram_x_q - {{(XW-1){1'b0}}, 1'b1};
        end
        else
        begin
          if (entry_mode_q[`EM_Y_INC])
            ram_y_q <= ram_y_q + {{(YW-1){1'b0}}, 1'b1};
          else
            ram_y_q <= ram_y_q - {{(YW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Readback shifts out on falling clock edges while the selector is high; bits past the
  // fourth byte read as zero until chip select ends the read.
  always @(posedge sys_clk_i)
  begin
    if (hw_rst)
    begin
      tx_q        <= 32'h00000000;
      tx_cnt_q    <= 6'h00;
      tx_active_q <= 1'b0;
      sda_q       <= 1'b0;
      sda_oe_q    <= 1'b0;
    end
    else if (cmd_byte)
    begin
      tx_q        <= init_code_q;
      tx_cnt_q    <= 6'h00;
      tx_active_q <= (rx_byte == `CMD_INIT_READ);
      sda_oe_q    <= 1'b0;
    end
    else if (!cs_active || sleeping)
    begin
      tx_active_q <= 1'b0;
      sda_oe_q    <= 1'b0;
    end
    else if (tx_active_q && scl_fall && dc_level)
    begin
      sda_q    <= tx_q[31] & (tx_cnt_q != `TX_BITS);
      sda_oe_q <= 1'b1;
      tx_q     <= {tx_q[30:0], 1'b0};
      if (tx_cnt_q != `TX_BITS)
        tx_cnt_q <= tx_cnt_q + 6'h01;
    end
  end

  // Register slave: one write and one read at a time, address and data in either order.
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      awready_q     <= 1'b1;
      wready_q      <= 1'b1;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_idx_q      <= 6'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      bvalid_q      <= 1'b0;
      bresp_q       <= `RESP_OKAY;
      clk_gate_on_q <= 1'b0;
      soft_rst_q    <= 1'b0;
    end
    else
    begin
      soft_rst_q <= 1'b0;
      if (s_axi_awvalid && awready_q)
      begin
        aw_full_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[7:2];
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (aw_full_q && w_full_q && !bvalid_q)
      begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (aw_idx_q <= `REG_ADDR) ? `RESP_OKAY : `RESP_SLVERR;
        if (aw_idx_q == `REG_CTRL && wstrb_q[0])
        begin
          clk_gate_on_q <= wdata_q[`CTRL_CLK_GATE_ON];
          soft_rst_q    <= wdata_q[`CTRL_SOFT_RESET];
        end
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always @*
  begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    case (s_axi_araddr[7:2])
      `REG_CTRL:       rd_data = {30'h00000000, 1'b0, clk_gate_on_q};
      `REG_STATUS:     rd_data = {24'h000000, 1'b0, entry_mode_q, 1'b0, sleep_mode_q, busy_q};
      `REG_GATE:       rd_data = {13'h0000, gate_scan_q, 7'h00, gate_lines_q};
      `REG_GATE_LEVEL: rd_data = {27'h0000000, gate_level_q};
      `REG_SOURCE:     rd_data = {8'h00, src_lo_q, src_hi2_q, src_hi1_q};
      `REG_INIT_CODE:  rd_data = init_code_q;
      `REG_ADDR:       rd_data = {{(16-YW){1'b0}}, ram_y_q, {(16-XW){1'b0}}, ram_x_q};
      default:         rd_ok   = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign sda_o         = sda_q;
  assign sda_oe_o      = sda_oe_q;
  assign busy_o        = busy_q;
  assign ram_we_o      = ram_we_q;
  assign ram_data_o    = ram_data_q;
  assign ram_x_o       = ram_x_q;
  assign ram_y_o       = ram_y_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rvalid  = rvalid_q;

endmodule // epaper_command_decoder

// ===== hdl/serial_byte_receiver.v
`timescale 1ns/10ps
`include "epaper_cmd_defs.vh"

module serial_byte_receiver
(
  input  wire       sys_clk_i,
  input  wire       rst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  input  wire       cs_n_i,
  input  wire       dc_i,
  output reg        byte_valid_o,
  output reg  [7:0] byte_o,
  output reg        byte_dc_o,
  output wire       scl_fall_o,
  output wire       cs_active_o,
  output wire       dc_level_o
);

  reg  [3:0] s1_q;
  reg  [3:0] s2_q;
  reg        scl_prev_q;
  reg  [6:0] shift_q;
  reg  [2:0] bit_cnt_q;
  wire       scl_rise;

  // Stage one feeds stage two only; edges are found between stage two and its delayed copy.
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s1_q       <= 4'hF;
      s2_q       <= 4'hF;
      scl_prev_q <= 1'b1;
    end
    else
    begin
      s1_q       <= {dc_i, cs_n_i, sda_i, scl_i};
      s2_q       <= s1_q;
      scl_prev_q <= s2_q[0];
    end
  end

  assign scl_rise    = s2_q[0] & ~scl_prev_q;
  assign scl_fall_o  = ~s2_q[0] & scl_prev_q & ~s2_q[2];
  assign cs_active_o = ~s2_q[2];
  assign dc_level_o  = s2_q[3];

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      shift_q      <= 7'h00;
      bit_cnt_q    <= 3'h0;
      byte_valid_o <= 1'b0;
      byte_o       <= 8'h00;
      byte_dc_o    <= 1'b0;
    end
    else
    begin
      byte_valid_o <= 1'b0;
      if (s2_q[2])
        bit_cnt_q <= 3'h0;
      else if (scl_rise)
      begin
        shift_q   <= {shift_q[5:0], s2_q[1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == `BYTE_LAST_BIT)
        begin
          byte_valid_o <= 1'b1;
          byte_o       <= {shift_q, s2_q[1]};
          byte_dc_o    <= s2_q[3];
        end
      end
    end
  end

endmodule // serial_byte_receiver

// ===== verif/epaper_command_decoder_props.sv
`timescale 1ns/10ps
module epaper_command_decoder_props
#(
  parameter XW = 8,
  parameter YW = 9
)
(
  input wire logic          sys_clk_i,
  input wire logic          rst_i,
  input wire logic          pin_driven_restart_n_i,
  input wire logic          cs_n_i,
  input wire logic          dc_i,
  input wire logic          sda_oe_o,
  input wire logic          busy_o,
  input wire logic          ram_we_o,
  input wire logic [XW-1:0] ram_x_o,
  input wire logic [YW-1:0] ram_y_o
);
  logic [11:0] busy_run_q;
  // A programming run ends well before 2100 cycles, so a longer busy run can only be deep sleep.
  always @(posedge sys_clk_i)
  begin
    if (rst_i || !pin_driven_restart_n_i || !busy_o)
      busy_run_q <= 12'h000;
    else if (busy_run_q != 12'hFFF)
      busy_run_q <= busy_run_q + 12'h001;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence axis_step;
    (ram_x_o != $past(ram_x_o)) != (ram_y_o != $past(ram_y_o));
  endsequence
  sequence busy_kept;
    busy_o [*8];
  endsequence
  chk_we_pulse: assert property (ram_we_o |=> !ram_we_o)
    else $error("ram write strobe longer than one cycle");
  chk_ram_step: assert property (ram_we_o |-> ##[1:2] axis_step)
    else $error("address counter did not step on exactly one axis");
  chk_busy_span: assert property (disable iff (rst_i || !pin_driven_restart_n_i)
    $rose(busy_o) |-> busy_kept)
    else $error("busy dropped right after rising");
  chk_sleep_hold: assert property (disable iff (rst_i || !pin_driven_restart_n_i)
    busy_run_q > 12'h834 |=> busy_o)
    else $error("busy left deep sleep without a restart");
  chk_sleep_quiet: assert property (busy_run_q > 12'h834 |-> !ram_we_o && !sda_oe_o)
    else $error("activity while in deep sleep");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !busy_o && !sda_oe_o && !ram_we_o)
    else $error("outputs not idle after reset");
  chk_oe_release: assert property (cs_n_i [*6] |-> !sda_oe_o)
    else $error("data line driven while deselected");
  chk_oe_start: assert property ($rose(sda_oe_o) |-> !cs_n_i && dc_i)
    else $error("readback started outside a data phase");
endmodule // epaper_command_decoder_props

// ===== verif/host_link_model.sv
`timescale 1ns/10ps
module host_link_model
(
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic      cs_n_o,
  output logic      dc_o
);
  logic drv_q;
  initial
  begin
    scl_o = 1'h0;
    sda_o = 1'h0;
    cs_n_o = 1'h1;
    dc_o = 1'h0;
    drv_q = 1'h1;
  end
  // Nothing pulls the line, so a released host output keeps toggling and stale bits never pass as data.
  always @(posedge clk_i)
    if (!drv_q)
      sda_o <= ~sda_o;
  task automatic half();
    repeat (20) @(posedge clk_i);
  endtask
  task automatic send(input logic sel, input logic [7:0] b);
    @(posedge clk_i);
    cs_n_o <= 1'h0;
    dc_o <= sel;
    drv_q <= 1'h1;
    half();
    for (int i = 7; i >= 0; i--)
    begin
      sda_o <= b[i];
      half();
      scl_o <= 1'h1;
      half();
      scl_o <= 1'h0;
    end
  endtask
  task automatic read32(output logic [31:0] d);
    half();
    dc_o <= 1'h1;
    drv_q <= 1'h0;
    for (int i = 0; i < 32; i++)
    begin
      scl_o <= 1'h1;
      half();
      scl_o <= 1'h0;
      half();
      d = {d[30:0], line_i};
    end
  endtask
  task automatic done();
    half();
    cs_n_o <= 1'h1;
    drv_q <= 1'h1;
    half();
  endtask
endmodule // host_link_model

// ===== verif/test_epaper_command_decoder.sv
`timescale 1ns/10ps
`include "epaper_cmd_defs.vh"
module test_epaper_command_decoder;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        rstn = 1'h1;
  logic        scl, sda_h, cs_n, dc, sda_d, oe, busy, we;
  logic [7:0]  wd, xo;
  logic [8:0]  yo;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          err_count = 0;
  int          num_checks = 0;
  int          ex = 0, ey = 0, em = 3;
  logic [7:0]  q[$];
  wire         line = oe ? sda_d : sda_h;
  always #2 clk = ~clk;
  host_link_model u_host (.clk_i(clk), .line_i(line), .scl_o(scl), .sda_o(sda_h), .cs_n_o(cs_n), .dc_o(dc));
  epaper_command_decoder u_dut (.sys_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(line), .sda_o(sda_d),
    .sda_oe_o(oe), .cs_n_i(cs_n), .dc_i(dc), .pin_driven_restart_n_i(rstn), .busy_o(busy), .ram_we_o(we),
    .ram_data_o(wd), .ram_x_o(xo), .ram_y_o(yo), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'h1)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    chk_resp(s_axi_bresp, er);
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'h1)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd({idx, 2'h0}, d, r);
    chk_word(d, exp);
    chk_resp(r, idx > 6'h06 ? `RESP_SLVERR : `RESP_OKAY);
  endtask
  task automatic defaults();
    rd_chk(6'h01, 32'h00000030);
    rd_chk(6'h02, 32'h00000127);
    rd_chk(6'h03, 32'h00000017);
    rd_chk(6'h04, 32'h0032AC41);
    rd_chk(6'h06, 32'h00000000);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // The model steps its own counter copy only after comparing, the same order the hardware uses.
  always @(posedge clk)
    if (we === 1'h1)
    begin
      chk_word({7'h00, wd, xo, yo}, {7'h00, q.pop_front(), ex[7:0], ey[8:0]});
      if (em[2])
        ey = (ey + (em[1] ? 1 : -1)) & 511;
      else
        ex = (ex + (em[0] ? 1 : -1)) & 255;
    end
  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial
  begin
    logic [31:0] d, v;
    int          n;
    v = $urandom(1);
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    defaults();
    rd_chk(6'h07, 32'h0);
    axi_wr(8'h0C, 32'hFFFFFFFF, `RESP_OKAY);
    axi_wr(8'h40, 32'h0, `RESP_SLVERR);
    rd_chk(6'h03, 32'h00000017);
    $display("test defaults done");
    v = $urandom;
    d = $urandom;
    u_host.send(1'h0, `CMD_GATE_SETUP);
    u_host.send(1'h1, v[7:0]);
    u_host.send(1'h1, {7'h00, v[8]});
    u_host.send(1'h1, {5'h00, v[11:9]});
    u_host.send(1'h0, `CMD_GATE_LEVEL);
    u_host.send(1'h1, {3'h0, v[16:12]});
    u_host.send(1'h0, `CMD_SOURCE_LEVEL);
    for (int i = 0; i < 3; i++)
      u_host.send(1'h1, d[8*i+:8]);
    u_host.done();
    rd_chk(6'h02, {13'h0000, v[11:9], 7'h00, v[8:0]});
    rd_chk(6'h03, {27'h0, v[16:12]});
    rd_chk(6'h04, {8'h00, d[23:0]});
    $display("test settings done");
    v = $urandom;
    u_host.send(1'h0, `CMD_INIT_WRITE);
    for (int i = 3; i >= -1; i--)
      u_host.send(1'h1, i < 0 ? 8'hFF : v[8*i+:8]);
    u_host.done();
    rd_chk(6'h05, v);
    u_host.send(1'h0, `CMD_INIT_READ);
    u_host.read32(d);
    u_host.done();
    chk_word(d, v);
    $display("test init code done");
    u_host.send(1'h0, `CMD_INIT_PROGRAM);
    u_host.done();
    chk_word({31'h0, busy}, 32'h0);
    axi_wr(8'h00, 32'h1, `RESP_OKAY);
    u_host.send(1'h0, `CMD_INIT_PROGRAM);
    u_host.done();
    chk_word({31'h0, busy}, 32'h1);
    n = 0;
    while (busy === 1'h1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk_word({31'h0, n > 1900 && n < 2000}, 32'h1);
    $display("test program done");
    for (int m = 0; m < 8; m++)
    begin
      u_host.send(1'h0, `CMD_ENTRY_MODE);
      u_host.send(1'h1, m[7:0]);
      em = m;
      u_host.send(1'h0, `CMD_RAM_WRITE);
      for (int i = 0; i < 3; i++)
      begin
        v = $urandom;
        q.push_back(v[7:0]);
        u_host.send(1'h1, v[7:0]);
      end
      u_host.done();
      rd_chk(6'h01, {25'h0, m[2:0], 4'h0});
      rd_chk(6'h06, {7'h00, ey[8:0], 8'h00, ex[7:0]});
    end
    axi_wr(8'h00, 32'h2, `RESP_OKAY);
    ex = 0;
    ey = 0;
    em = 3;
    defaults();
    $display("test entry and ram done");
    for (int k = 1; k < 4; k++)
    begin
      u_host.send(1'h0, `CMD_DEEP_SLEEP);
      u_host.send(1'h1, k[7:0]);
      u_host.done();
      repeat (2200) @(posedge clk);
      u_host.send(1'h0, `CMD_ENTRY_MODE);
      u_host.send(1'h1, 8'h00);
      u_host.done();
      chk_word({31'h0, busy}, {31'h0, k[0]});
      rd_chk(6'h01, {25'h0, k[0] ? 3'h3 : 3'h0, 1'h0, k[1:0], k[0]});
      axi_wr(8'h00, 32'h2, `RESP_OKAY);
      rd_chk(6'h01, {25'h0, 3'h3, 1'h0, k[1:0], k[0]});
      rstn <= 1'h0;
      repeat (6) @(posedge clk);
      rstn <= 1'h1;
      repeat (6) @(posedge clk);
      defaults();
    end
    $display("test deep sleep done");
    report_and_stop();
  end
endmodule // test_epaper_command_decoder
bind epaper_command_decoder epaper_command_decoder_props #(.XW(XW), .YW(YW)) u_props (.sys_clk_i, .rst_i,
  .pin_driven_restart_n_i, .cs_n_i, .dc_i, .sda_oe_o, .busy_o, .ram_we_o, .ram_x_o, .ram_y_o);
